//--- hdl/ddl_latch_ctrl.sv
// input and converter latch control of the dual 14-bit current-output converter
`timescale 1ns/10ps
module ddl_latch_ctrl
    import ddl_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // configuration
    input  wire logic              modeDual,
    input  wire logic              sleep,
    // data ports
    input  wire logic [DATA_W-1:0] dataCh1,
    input  wire logic [DATA_W-1:0] dataCh2,
    // strobes and update clocks
    input  wire logic              writeStrobeCh1,
    input  wire logic              updateClockCh1,
    input  wire logic              writeStrobeCh2,
    input  wire logic              updateClockCh2,
    // converter latches
    output logic [DATA_W-1:0]      convCh1,
    output logic [DATA_W-1:0]      convCh2,
    output logic                   updateStall,
    // power state
    output logic                   outputsOn,
    output logic                   outputsValid,
    // sample stream
    output logic                   sampleValid,
    output ddl_pair_type           samplePair,
    input  wire logic              sampleReady
);

    localparam int ENTRY_MAX = SLEEP_ENTRY_CYCLES; // bound for entry check

    // ****************************************
    // pin roles and edges
    // ****************************************
    logic prevW1;                               // last sampled strobe 1
    logic prevC1;                               // last sampled clock 1
    logic prevW2;                               // last sampled strobe 2
    logic prevC2;                               // last sampled clock 2
    logic riseW1;
    logic riseC1;
    logic riseW2;
    logic riseC2;
    logic pairWriteStrobeRise;                  // interleaved strobe edge
    logic pairUpdateClockRise;                  // interleaved clock edge
    logic channelSteerSelect;                   // high steers to channel one
    logic dividerHold;                          // high holds the divider in reset

    // inputs are synchronous, so one stage of history gives the edges;
    // a limitation: pins must hold each level for a full clock cycle
    assign riseW1 = ddl_rise(prevW1, writeStrobeCh1);
    assign riseC1 = ddl_rise(prevC1, updateClockCh1);
    assign riseW2 = ddl_rise(prevW2, writeStrobeCh2);
    assign riseC2 = ddl_rise(prevC2, updateClockCh2);
    // channel-one and channel-two pins change meaning in interleaved mode
    assign pairWriteStrobeRise = riseW1;
    assign pairUpdateClockRise = riseC1;
    assign channelSteerSelect  = writeStrobeCh2;
    assign dividerHold         = updateClockCh2;

    // edge history, no duty-cycle demand beyond one level per cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevW1 <= 1'b0;
            prevC1 <= 1'b0;
            prevW2 <= 1'b0;
            prevC2 <= 1'b0;
        end else begin
            prevW1 <= writeStrobeCh1;
            prevC1 <= updateClockCh1;
            prevW2 <= writeStrobeCh2;
            prevC2 <= updateClockCh2;
        end
    end

    // ****************************************
    // input latches, divider and converter latches
    // ****************************************
    logic [DATA_W-1:0] inLatch1;                // channel-one input latch
    logic [DATA_W-1:0] inLatch2;                // channel-two input latch
    logic              divPhase;                // high: next pair edge is skipped
    logic              pend1;                   // update owed to channel one
    logic              pend2;                   // update owed to channel two
    logic              req1;                    // update edge for channel one
    logic              req2;                    // update edge for channel two
    logic              eff1;
    logic              eff2;
    logic              bufReady;                // buffer can take a pair
    logic              push;                    // converter latches load now
    logic [DATA_W-1:0] next_inLatch1;
    logic [DATA_W-1:0] next_inLatch2;
    logic              next_divPhase;
    logic              next_pend1;
    logic              next_pend2;
    logic [DATA_W-1:0] next_conv1;
    logic [DATA_W-1:0] next_conv2;
    ddl_pair_type      pushPair;

    // capture, divide and transfer; the update reads the old input latch, so
    // a clock edge together with a strobe converts the previous word
    always_comb begin
        next_inLatch1 = inLatch1;
        next_inLatch2 = inLatch2;
        next_divPhase = divPhase;
        req1          = 1'b0;
        req2          = 1'b0;
        if (modeDual == MODE_DUAL) begin
            // independent ports, strobes and clocks
            if (riseW1) begin
                next_inLatch1 = dataCh1;
            end
            if (riseW2) begin
                next_inLatch2 = dataCh2;
            end
            req1          = riseC1;
            req2          = riseC2;
            next_divPhase = 1'b0;
        end else begin
            // one port steered by the select level
            if (pairWriteStrobeRise) begin
                if (channelSteerSelect) begin
                    next_inLatch1 = dataCh1;
                end else begin
                    next_inLatch2 = dataCh1;
                end
            end
            if (dividerHold) begin
                next_divPhase = 1'b0;
            end else if (pairUpdateClockRise) begin
                req1          = ~divPhase;
                req2          = ~divPhase;
                next_divPhase = ~divPhase;
            end
        end
        // a stalled update stays owed; a new edge never clears it
        eff1       = pend1 | req1;
        eff2       = pend2 | req2;
        push       = (eff1 | eff2) & bufReady;
        next_pend1 = eff1 & ~push;
        next_pend2 = eff2 & ~push;
        // straight binary pass-through, bit order kept msb to lsb
        next_conv1 = (push & eff1) ? inLatch1[CODE_MSB:CODE_LSB] : convCh1;
        next_conv2 = (push & eff2) ? inLatch2[CODE_MSB:CODE_LSB] : convCh2;
        pushPair.ch1 = next_conv1;
        pushPair.ch2 = next_conv2;
    end

    // latch registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            inLatch1    <= CODE_RESET;
            inLatch2    <= CODE_RESET;
            divPhase    <= 1'b0;
            pend1       <= 1'b0;
            pend2       <= 1'b0;
            convCh1     <= CODE_RESET;
            convCh2     <= CODE_RESET;
            updateStall <= 1'b0;
        end else begin
            inLatch1    <= next_inLatch1;
            inLatch2    <= next_inLatch2;
            divPhase    <= next_divPhase;
            pend1       <= next_pend1;
            pend2       <= next_pend2;
            convCh1     <= next_conv1;
            convCh2     <= next_conv2;
            updateStall <= next_pend1 | next_pend2;
        end
    end

    // every converted pair is offered downstream; back-pressure stalls loads
    ddl_pair_buf #(
        .WIDTH (2 * DATA_W),
        .DEPTH (BUF_DEPTH)
    ) ddl_pair_buf_i (
        .clk      (clk),
        .rst      (rst),
        .inValid  (push),
        .inData   (pushPair),
        .inReady  (bufReady),
        .outValid (sampleValid),
        .outData  (samplePair),
        .outReady (sampleReady)
    );

    // ****************************************
    // sleep and wake
    // ****************************************
    ddl_pwr_type       powState;
    ddl_pwr_type       next_powState;
    logic [WAKE_W-1:0] wakeCount;               // cycles left in wake-up
    logic [WAKE_W-1:0] next_wakeCount;

    // reset lands in the awake state, as an unconnected sleep pin would
    always_comb begin
        next_powState  = powState;
        next_wakeCount = wakeCount;
        case (powState)
            PWR_ON: begin
                if (sleep) begin
                    next_powState = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (!sleep) begin
                    next_powState  = PWR_WAKE;
                    next_wakeCount = WAKE_W'(WAKE_CYCLES - 1);
                end
            end
            PWR_WAKE: begin
                if (sleep) begin
                    next_powState = PWR_DOWN;
                end else if (wakeCount == '0) begin
                    next_powState = PWR_ON;
                end else begin
                    next_wakeCount = wakeCount - 1'b1;
                end
            end
            default: begin
                next_powState = PWR_DOWN;
            end
        endcase
    end

    // one cycle to power down, well inside the entry limit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powState     <= PWR_ON;
            wakeCount    <= '0;
            outputsOn    <= 1'b1;
            outputsValid <= 1'b1;
        end else begin
            powState     <= next_powState;
            wakeCount    <= next_wakeCount;
            outputsOn    <= (next_powState != PWR_DOWN);
            outputsValid <= (next_powState == PWR_ON);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dual_ch1_capture_a: assert property (modeDual && riseW1 |=>
        inLatch1 == $past(dataCh1))
        else $error("channel-one strobe did not capture the word");
    dual_ch2_capture_a: assert property (modeDual && riseW2 |=>
        inLatch2 == $past(dataCh2))
        else $error("channel-two strobe did not capture its own port");
    msb_kept_a: assert property (push && eff1 |=> convCh1 == $past(inLatch1))
        else $error("converter code differs from the input latch");
    steer_one_a: assert property (!modeDual && riseW1 && writeStrobeCh2 |=>
        inLatch1 == $past(dataCh1) && $stable(inLatch2))
        else $error("select high did not steer to channel one");
    steer_two_a: assert property (!modeDual && riseW1 && !writeStrobeCh2 |=>
        inLatch2 == $past(dataCh1) && $stable(inLatch1))
        else $error("select low did not steer to channel two");
    hold_blocks_a: assert property (!modeDual && updateClockCh2 |-> !req1 && !req2)
        else $error("pair clock acted while the divider was held");
    divide_two_a: assert property (!modeDual && !updateClockCh2 && riseC1 && !divPhase
        |-> req1 && req2 ##1 (divPhase throughout (!riseC1 [*1])))
        else $error("divider phase wrong after an update");
    skip_edge_a: assert property (!modeDual && divPhase && riseC1 |-> !req1 && !req2)
        else $error("pair clock updated on a skipped edge");
    sleep_entry_a: assert property ($rose(sleep) |-> ##[1:ENTRY_MAX] !outputsOn)
        else $error("power-down entry too slow");
    sleep_off_a: assert property (sleep |=> !outputsOn && !outputsValid)
        else $error("current still on while asleep");
    wake_done_a: assert property ($rose(outputsValid) |->
        $past(powState) == PWR_WAKE && $past(wakeCount) == '0)
        else $error("outputs valid before wake-up time");
    conv_hold_a: assert property (!push |=> $stable(convCh1) && $stable(convCh2))
        else $error("converter latch changed without an update");

    dual_update_c: cover property (modeDual && riseC1 && riseC2 && push);
    pair_update_c: cover property (!modeDual && $fell(updateClockCh2) ##[1:8] push);
    stall_c:       cover property (updateStall [*3] ##0 push);
    wake_c:        cover property ($rose(outputsValid));

endmodule

//--- hdl/ddl_pkg.sv
// shared constants, carrier types and helpers of the dual converter input latch
package ddl_pkg;

    // ****************************************
    // word layout
    // ****************************************
    localparam int DATA_W   = 14;               // sample word width
    localparam int CODE_MSB = 13;               // data_bit_msb position
    localparam int CODE_LSB = 0;                // data_bit_lsb position
    localparam logic [13:0] CODE_RESET = 14'h0000; // latch contents after reset
    localparam logic MODE_DUAL = 1'b1;          // mode select level for dual port

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 10;         // 100 MHz system clock
    localparam int SLEEP_ENTRY_NS = 50;         // longest power-down entry time
    localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1
                                      : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int WAKE_TIME_US   = 5;          // power-up time after sleep release
    localparam int WAKE_CYCLES    = (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int WAKE_W         = $clog2(WAKE_CYCLES + 1);
    localparam int BUF_DEPTH      = 2;          // entries in the sample buffer

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0] ch1;                 // channel-one converter code
        logic [DATA_W-1:0] ch2;                 // channel-two converter code
    } ddl_pair_type;

    typedef enum logic [1:0] {
        PWR_ON   = 2'b00,                       // outputs driving current
        PWR_DOWN = 2'b01,                       // current off, powered down
        PWR_WAKE = 2'b10                        // recovering, outputs not valid
    } ddl_pwr_type;

    // rising edge of a sampled control pin
    function automatic logic ddl_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

endpackage

//--- hdl/ddl_pair_buf.sv
// two-entry buffer for converter word pairs, outputs taken from registers
`timescale 1ns/10ps
module ddl_pair_buf
    import ddl_pkg::*;
#(
    parameter int WIDTH = 2 * DATA_W,           // entry width
    parameter int DEPTH = BUF_DEPTH             // entry count, only 2 supported
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // draining side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (DEPTH != 2) begin : g_depth_check
        $error("ddl_pair_buf supports a depth of 2 only");
    end

    logic [WIDTH-1:0] second;                   // entry behind the head
    logic             secondValid;              // second entry occupied
    logic [WIDTH-1:0] next_outData;
    logic             next_outValid;
    logic [WIDTH-1:0] next_second;
    logic             next_secondValid;

    // head sits in outData so the drain sees a register, shift on pop
    always_comb begin
        logic push;
        logic pop;
        push             = inValid & inReady;
        pop              = outValid & outReady;
        next_outData     = outData;
        next_outValid    = outValid;
        next_second      = second;
        next_secondValid = secondValid;
        if (pop) begin
            next_outValid    = secondValid | push;
            next_outData     = secondValid ? second : inData;
            next_secondValid = secondValid & push;
            next_second      = inData;
        end else if (push) begin
            if (!outValid) begin
                next_outValid = 1'b1;
                next_outData  = inData;
            end else begin
                next_secondValid = 1'b1;
                next_second      = inData;
            end
        end
    end

    // registers only; ready is honest full, no look-ahead on pop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outData     <= '0;
            outValid    <= 1'b0;
            second      <= '0;
            secondValid <= 1'b0;
            inReady     <= 1'b1;
        end else begin
            outData     <= next_outData;
            outValid    <= next_outValid;
            second      <= next_second;
            secondValid <= next_secondValid;
            inReady     <= ~next_secondValid;
        end
    end

endmodule

//--- sim/ddl_source.sv
// sample source model driving words, strobes and update clocks
`timescale 1ns/10ps
module ddl_source
    import ddl_pkg::*;
(
    // clock
    input  wire logic         clk,
    // data ports
    output logic [DATA_W-1:0] dataCh1,
    output logic [DATA_W-1:0] dataCh2,
    // strobes and update clocks
    output logic              writeStrobeCh1,
    output logic              updateClockCh1,
    output logic              writeStrobeCh2,
    output logic              updateClockCh2
);
    logic [3:0] pins;   // {wr1, update_clock_ch1, wr2, update_clock_ch2}

    assign {writeStrobeCh1, updateClockCh1, writeStrobeCh2, updateClockCh2} = pins;

    // everything low and idle at time zero
    initial begin
        pins    = 4'h0;
        dataCh1 = 14'h0000;
        dataCh2 = 14'h0000;
    end

    // level pins (steer select, divider hold) are set and then held
    task setLevel(input logic [3:0] mask, input logic [3:0] val);
        @(posedge clk);
        pins <= (pins & ~mask) | (val & mask);
    endtask

    // one high cycle then one low cycle on the masked pins
    // clock rises with the strobe at the earliest, never before it
    task pulse(input logic [3:0] rise, input logic [13:0] d1, input logic [13:0] d2);
        @(posedge clk);
        dataCh1 <= d1;
        dataCh2 <= d2;
        pins    <= pins | rise;
        @(posedge clk);
        pins    <= pins & ~rise;
        // data turned over once taken, away from the next rising edge
        dataCh1 <= ~d1;
        dataCh2 <= ~d2;
    endtask
endmodule

//--- sim/dual_dac_input_latch_test.sv
// self-checking testbench of the dual converter input latch control
`timescale 1ns/10ps
module dual_dac_input_latch_test
    import ddl_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [3:0] WR1 = 4'h8;   // strobe ch1 / pair strobe
    localparam logic [3:0] CK1 = 4'h4;   // clock ch1 / pair clock
    localparam logic [3:0] WR2 = 4'h2;   // strobe ch2 / steer select
    localparam logic [3:0] CK2 = 4'h1;   // clock ch2 / divider hold
    logic              clk;
    logic              rst;
    logic              modeDual;
    logic              sleep;
    logic [DATA_W-1:0] dataCh1;
    logic [DATA_W-1:0] dataCh2;
    logic              writeStrobeCh1;
    logic              updateClockCh1;
    logic              writeStrobeCh2;
    logic              updateClockCh2;
    logic [DATA_W-1:0] convCh1;
    logic [DATA_W-1:0] convCh2;
    logic              updateStall;
    logic              outputsOn;
    logic              outputsValid;
    logic              sampleValid;
    ddl_pair_type      samplePair;
    logic              sampleReady;
    int                n_fail;
    int                compares;
    int                i;

    // ****************************************
    // instances
    // ****************************************
    ddl_latch_ctrl ddl_latch_ctrl_i (.clk(clk), .rst(rst), .modeDual(modeDual),
        .sleep(sleep), .dataCh1(dataCh1), .dataCh2(dataCh2),
        .writeStrobeCh1(writeStrobeCh1), .updateClockCh1(updateClockCh1),
        .writeStrobeCh2(writeStrobeCh2), .updateClockCh2(updateClockCh2),
        .convCh1(convCh1), .convCh2(convCh2), .updateStall(updateStall),
        .outputsOn(outputsOn), .outputsValid(outputsValid), .sampleValid(sampleValid),
        .samplePair(samplePair), .sampleReady(sampleReady));
    ddl_source ddl_source_i (.clk(clk), .dataCh1(dataCh1), .dataCh2(dataCh2),
        .writeStrobeCh1(writeStrobeCh1), .updateClockCh1(updateClockCh1),
        .writeStrobeCh2(writeStrobeCh2), .updateClockCh2(updateClockCh2));

    // ****************************************
    // helpers
    // ****************************************
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare one value, count it, report a mismatch at once
    task check(input logic [27:0] seen, input logic [27:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // interleaved write: select held first, then the pair strobe
    task iqWrite(input logic sel, input logic [13:0] d);
        ddl_source_i.setLevel(WR2, sel ? WR2 : 4'h0);
        ddl_source_i.pulse(WR1, d, 14'h0000);
    endtask

    // counts, verdict and end of run
    task complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // full buffer stalls a load, pop releases it, drain to empty
    task test_buffer();
        ddl_source_i.pulse(WR1, 14'h3fff, 14'h0000);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        ddl_source_i.pulse(WR1, 14'h2001, 14'h0000);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        ddl_source_i.pulse(WR1, 14'h0aaa, 14'h0000);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check(samplePair, {14'h3fff, 14'h0000}, "head full scale");
        check(updateStall, 1'b1, "stall when full");
        check(convCh1, 14'h2001, "msb and lsb word");
        @(posedge clk);
        sampleReady <= 1'b1;
        @(posedge clk);
        sampleReady <= 1'b0;
        #1;
        check(samplePair, {14'h2001, 14'h0000}, "second head");
        for (i = 0; i < 20 && updateStall !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        #1;
        check(convCh1, 14'h0aaa, "owed load done");
        @(posedge clk);
        sampleReady <= 1'b1;
        for (i = 0; i < 20 && sampleValid !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        #1;
        check(sampleValid, 1'b0, "drained");
        $display("test_buffer done");
    endtask

    // two independent ports, clock with strobe converts the old word
    task test_dual();
        ddl_source_i.pulse(WR2, 14'h0000, 14'h1234);
        #1;
        check({convCh1, convCh2}, {14'h0aaa, 14'h0000}, "write only");
        ddl_source_i.pulse(CK2, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h0aaa, 14'h1234}, "ch2 update");
        ddl_source_i.pulse(WR1 | CK1, 14'h0555, 14'h0000);
        #1;
        check(convCh1, 14'h0aaa, "clock with strobe");
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h0555, 14'h1234}, "ch1 update");
        // both ports written in one cycle, then both clocks raised together in the next pulse
        ddl_source_i.pulse(WR1 | WR2, 14'h3fff, 14'h2aaa);
        ddl_source_i.pulse(CK1 | CK2, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h3fff, 14'h2aaa}, "both update");
        $display("test_dual done");
    endtask

    // steering, divider hold and divide by two
    task test_interleaved();
        @(posedge clk);
        modeDual <= 1'b0;
        ddl_source_i.setLevel(CK2, CK2);
        // one word per channel in each update period
        iqWrite(1'b1, 14'h0111);
        iqWrite(1'b0, 14'h0222);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h3fff, 14'h2aaa}, "held clock");
        ddl_source_i.setLevel(CK2, 4'h0);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h0111, 14'h0222}, "first load");
        iqWrite(1'b1, 14'h0333);
        iqWrite(1'b0, 14'h0444);
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h0111, 14'h0222}, "skipped edge");
        ddl_source_i.pulse(CK1, 14'h0000, 14'h0000);
        #1;
        check({convCh1, convCh2}, {14'h0333, 14'h0444}, "second load");
        $display("test_interleaved done");
    endtask

    // power down within one cycle, wake after about 500 cycles
    task test_sleep();
        @(posedge clk);
        sleep <= 1'b1;
        @(posedge clk);
        #1;
        check({outputsOn, outputsValid}, 2'b00, "powered down");
        @(posedge clk);
        sleep <= 1'b0;
        repeat (450) @(posedge clk);
        #1;
        check(outputsValid, 1'b0, "still waking");
        for (i = 0; i < 100 && outputsValid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        #1;
        check({outputsOn, outputsValid}, 2'b11, "awake again");
        $display("test_sleep done");
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        n_fail      = 0;
        compares    = 0;
        rst         = 1'b1;
        modeDual    = MODE_DUAL;
        sleep       = 1'b0;   // pull-down level when left open
        sampleReady = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({convCh1, convCh2}, {CODE_RESET, CODE_RESET}, "reset codes");
        check({outputsOn, sampleValid}, 2'b10, "reset flags");
        test_buffer();
        test_dual();
        test_interleaved();
        test_sleep();
        complete_run();
    end

    // cut a hang short well beyond the expected run
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
endmodule
